// ===== rtl/srs_top.sv
/*
 * Ratio selection of a fractional-N synthesizer: picks a stored set by
 * the mode pins, scales its ratio, corrects for the reference
 * predivider, derives the internal timing tick and drives the modulator.
 * Assumes mode and reference pins are asynchronous to mclk, global
 * parameters are static, and mclk is well above the reference rate.
 */
// What this block does
// (R1) Mode pins 00 to 11 pick stored ratio slot and set 0 to 3.
// (R2) Four sets kept permanently, switched live by the mode pins.
// (R3) Global parameters stay the same whatever the mode pins do.
// (R4) Each user ratio is an unsigned 32-bit fixed-point value.
// (R5) Upper 12 bits integer, lower 20 bits binary fraction.
// (R6) Ratios reach about 4096 with about 0.954 ppm steps.
// (R7) Active scaler multiplies by 0.5, 0.25, 0.125 or 0.0625.
// (R8) Scaling never alters the stored slots, only the derived ratio.
// (R9) Scaler enabled only by the aux pin under the matching function.
// (R10) Effective ratio is user ratio times scaler factor.
// (R11) Predivider is compensated so the effective ratio is output over input.
// (R12) Configurer avoids scaler settings that overflow or truncate.
// (R13) Internal timing clock is the reference divided by the predivider.
// (R14) Configurer keeps the divided reference within its allowed range.
// (R15) Output is the timing reference times the loop ratio N.
// (R16) Modulator dithers the integer divide so its mean is the ratio.
// (R17) Configurer uses code 10, 01, 00 for 8-14, 16-28, 32-56 MHz.
// (R18) Aux function 011: scaler on while aux pin high, off when low.
// (R19) A mode pin change drops lock while the new ratio settles.
// (R20) Predivider divides by 1, 2, 4 for codes 10, 01, 00.
`timescale 1ns/1ps
module srs_top
    import srs_pkg::*;
#(
    parameter int LOCK_CYC = LOCK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    // Pins from outside the clock domain
    input  wire logic [1:0]          config_set_select_pins,
    input  wire logic                aux_mode_pin,
    input  wire logic                reference_input_pin,
    // Global parameters
    input  wire logic [2:0]          aux_pin_function,
    input  wire logic [1:0]          ref_divider_select,
    // Slot programming
    input  wire logic                otp_wr_en,
    input  wire logic [1:0]          otp_wr_slot,
    input  wire logic [RATIO_W-1:0]  otp_wr_ratio,
    input  wire logic [SCALE_W-1:0]  otp_wr_scale,
    // Ratio results
    output logic [RATIO_W-1:0]       effective_ratio,
    output logic [LOOP_W-1:0]        loop_ratio,
    output logic [DIV_W-1:0]         loop_divide_value,
    // Timing and status
    output logic                     internal_timing_clock,
    output logic [1:0]               config_set_active,
    output logic                     ratio_scaler_active,
    output logic                     lock_lost
);

    // ========================================================
    // Internal carrier and sub-blocks
    srs_if lnk ();

    srs_ratio_store u_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .wr_en   (otp_wr_en),
        .wr_slot (otp_wr_slot),
        .wr_word ({otp_wr_scale, otp_wr_ratio}),   // [R2] [R4]
        .bus     (lnk.store)
    );

    srs_dsm u_dsm (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .bus     (lnk.dsm)
    );

    // ========================================================
    // Pin synchronisers
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync1_next;
    logic [3:0] sync2_next;
    logic [1:0] sel_sync;
    logic       aux_sync;
    logic       ref_sync;

    // Two flops on every asynchronous pin
    always_comb begin
        sync1_next = {reference_input_pin, aux_mode_pin, config_set_select_pins};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    assign sel_sync = sync2_reg[1:0];
    assign aux_sync = sync2_reg[2];
    assign ref_sync = sync2_reg[3];

    // ========================================================
    // Reference predivider and internal timing tick
    logic       ref_prev_reg;
    logic       ref_prev_next;
    logic [1:0] pdiv_cnt_reg;
    logic [1:0] pdiv_cnt_next;
    logic       tick_reg;
    logic       tick_next;
    logic [1:0] pdiv_shift;
    logic [1:0] pdiv_last;

    // Count reference rising edges; one tick per predivider period
    always_comb begin
        pdiv_shift    = srs_pdiv_shift(ref_divider_select);   // [R3] [R20]
        pdiv_last     = 2'((3'h1 << pdiv_shift) - 3'h1);
        ref_prev_next = ref_sync;
        pdiv_cnt_next = pdiv_cnt_reg;
        tick_next     = 1'b0;
        if (ref_sync && !ref_prev_reg) begin
            if (pdiv_cnt_reg >= pdiv_last) begin
                pdiv_cnt_next = PDIV_RST;
                tick_next     = 1'b1;                       // [R13]
            end else begin
                pdiv_cnt_next = pdiv_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_prev_reg <= 1'b0;
            pdiv_cnt_reg <= PDIV_RST;
            tick_reg     <= 1'b0;
        end else begin
            ref_prev_reg <= ref_prev_next;
            pdiv_cnt_reg <= pdiv_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    // ========================================================
    // Set selection and loop lock tracking
    srs_lock_type            lk_reg;
    srs_lock_type            lk_next;
    logic [1:0]              set_reg;
    logic [1:0]              set_next;
    logic                    aux_prev_reg;
    logic                    aux_prev_next;
    logic [LOCK_CNT_W-1:0]   lk_cnt_reg;
    logic [LOCK_CNT_W-1:0]   lk_cnt_next;
    logic                    lost_reg;
    logic                    lost_next;
    logic                    aux_upsets;
    logic                    upset;

    // Set follows the pins at once; any change restarts settling
    always_comb begin
        aux_upsets    = (aux_pin_function >= AUX_FN_RELK_LO)
                     && (aux_pin_function <= AUX_FN_RELK_HI);
        upset         = (sel_sync != set_reg)                       // [R19]
                     || (aux_upsets && (aux_sync != aux_prev_reg));
        set_next      = sel_sync;                                   // [R1] [R2]
        aux_prev_next = aux_sync;
        lk_next       = lk_reg;
        lk_cnt_next   = lk_cnt_reg;
        if (upset) begin
            lk_next     = LK_SETTLE;
            lk_cnt_next = '0;
        end else begin
            unique case (lk_reg)
                LK_SETTLE: begin
                    if (lk_cnt_reg >= LOCK_CNT_W'(LOCK_CYC - 1)) begin
                        lk_next = LK_RUN;
                    end else begin
                        lk_cnt_next = lk_cnt_reg + LOCK_CNT_W'(1);
                    end
                end
                LK_RUN: begin
                    lk_cnt_next = '0;
                end
            endcase
        end
        lost_next = (lk_next == LK_SETTLE);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lk_reg       <= LK_SETTLE;
            set_reg      <= SET_RST;
            aux_prev_reg <= 1'b0;
            lk_cnt_reg   <= '0;
            lost_reg     <= 1'b1;
        end else begin
            lk_reg       <= lk_next;
            set_reg      <= set_next;
            aux_prev_reg <= aux_prev_next;
            lk_cnt_reg   <= lk_cnt_next;
            lost_reg     <= lost_next;
        end
    end

    // ========================================================
    // Effective ratio and predivider correction
    logic [RATIO_W-1:0] eff_reg;
    logic [RATIO_W-1:0] eff_next;
    logic [LOOP_W-1:0]  loop_reg;
    logic [LOOP_W-1:0]  loop_next;
    logic               scl_reg;
    logic               scl_next;
    logic [RATIO_W-1:0] user_ratio;
    logic [SCALE_W-1:0] ratio_scale_select;

    // Scale a copy of the slot ratio; stored slots are only read
    always_comb begin
        user_ratio         = lnk.rd_word[SLOT_RATIO_LSB +: RATIO_W];  // [R5] [R8]
        ratio_scale_select = lnk.rd_word[SLOT_SCALE_LSB +: SCALE_W];
        scl_next           = (aux_pin_function == AUX_FN_SCALE)
                          && aux_sync;                                // [R9] [R18]
        if (scl_next) begin
            eff_next = srs_scale(user_ratio, ratio_scale_select);     // [R7] [R10]
        end else begin
            eff_next = user_ratio;                                    // [R6]
        end
        // Loop runs on the divided reference, so the ratio grows to match
        loop_next = LOOP_W'({2'h0, eff_reg} << pdiv_shift);          // [R11] [R15]
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            eff_reg  <= '0;
            loop_reg <= '0;
            scl_reg  <= 1'b0;
        end else begin
            eff_reg  <= eff_next;
            loop_reg <= loop_next;
            scl_reg  <= scl_next;
        end
    end

    // ========================================================
    // Carrier drive and outputs
    assign lnk.rd_slot    = set_reg;
    assign lnk.tick       = tick_reg;
    assign lnk.restart    = lost_reg;
    assign lnk.loop_ratio = loop_reg;

    assign effective_ratio       = eff_reg;
    assign loop_ratio            = loop_reg;
    assign loop_divide_value     = lnk.div_value;
    assign internal_timing_clock = tick_reg;
    assign config_set_active     = set_reg;
    assign ratio_scaler_active   = scl_reg;
    assign lock_lost             = lost_reg;

endmodule // srs_top

// ===== include/srs_pkg.sv
/*
 * Constants, types and shared arithmetic of the ratio-selection block.
 * Assumes a single 200 MHz clock; included before every design file.
 */
package srs_pkg;

    // ========================================================
    // Widths
    localparam int RATIO_W = 32;           // User ratio, 12.20 unsigned
    localparam int INT_W   = 12;           // Integer bits of a user ratio
    localparam int FRAC_W  = 20;           // Fraction bits of a user ratio
    localparam int SCALE_W = 2;            // Scale selector per set
    localparam int SLOT_W  = RATIO_W + SCALE_W;
    localparam int SLOTS   = 4;
    localparam int LOOP_W  = RATIO_W + 2;  // Ratio after predivider correction
    localparam int LINT_W  = LOOP_W - FRAC_W;
    localparam int DIV_W   = LINT_W + 1;   // Dithered integer divide value

    // ========================================================
    // Field positions in a stored slot word
    localparam int SLOT_RATIO_LSB = 0;
    localparam int SLOT_SCALE_LSB = RATIO_W;

    // ========================================================
    // Codes of the global parameters
    localparam logic [2:0] AUX_FN_SCALE   = 3'h3;  // Aux pin enables scaler
    localparam logic [2:0] AUX_FN_RELK_LO = 3'h3;  // Aux changes upset the loop
    localparam logic [2:0] AUX_FN_RELK_HI = 3'h6;
    localparam logic [1:0] REFDIV_BY1     = 2'h2;
    localparam logic [1:0] REFDIV_BY2     = 2'h1;
    localparam logic [1:0] REFDIV_BY4     = 2'h0;

    // ========================================================
    // Reset values
    localparam logic [1:0]        SET_RST   = 2'h0;
    localparam logic [SLOT_W-1:0] WORD_RST  = 34'h0_0000_0000;
    localparam logic [FRAC_W-1:0] ACC_RST   = 20'h0_0000;
    localparam logic [1:0]        PDIV_RST  = 2'h0;

    // ========================================================
    // Timing
    localparam int CLK_MHZ         = 200;
    localparam int LOCK_TIME_MS    = 3;    // Longest loop settling time
    localparam int LOCK_CYCLES_DEF = LOCK_TIME_MS * 1000 * CLK_MHZ;
    localparam int LOCK_CNT_W      = 20;

    // ========================================================
    // Loop lock state
    typedef enum logic {
        LK_SETTLE,
        LK_RUN
    } srs_lock_type;

    // Ratio scaled by 0.5, 0.25, 0.125 or 0.0625 (truncating shift)
    function automatic logic [RATIO_W-1:0] srs_scale(
        input logic [RATIO_W-1:0] ratio,
        input logic [SCALE_W-1:0] sel
    );
        return ratio >> ({1'b0, sel} + 3'h1);
    endfunction

    // Predivider as a shift count: by 1, 2 or 4; spare code acts as 1
    function automatic logic [1:0] srs_pdiv_shift(input logic [1:0] code);
        unique case (code)
            REFDIV_BY4: return 2'h2;
            REFDIV_BY2: return 2'h1;
            default:    return 2'h0;
        endcase
    endfunction

endpackage

// ===== include/srs_if.sv
/*
 * Internal carrier between the selector core, the ratio store and the
 * modulator. Assumes all three sit on one clock.
 */
`timescale 1ns/1ps
interface srs_if;
    import srs_pkg::*;

    logic [1:0]        rd_slot;
    logic [SLOT_W-1:0] rd_word;
    logic              tick;
    logic              restart;
    logic [LOOP_W-1:0] loop_ratio;
    logic [DIV_W-1:0]  div_value;

    modport store (input rd_slot, output rd_word);
    modport dsm   (input tick, input restart, input loop_ratio, output div_value);
    modport core  (output rd_slot, output tick, output restart, output loop_ratio,
                   input rd_word, input div_value);
endinterface

// ===== rtl/srs_ratio_store.sv
/*
 * Four permanent slots, each a user ratio and its scale selector.
 * Assumes slot writes come from programming logic on the same clock.
 */
`timescale 1ns/1ps
module srs_ratio_store
    import srs_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // Programming port
    input  wire logic              wr_en,
    input  wire logic [1:0]        wr_slot,
    input  wire logic [SLOT_W-1:0] wr_word,
    // Read side
    srs_if.store                   bus
);

    logic [SLOT_W-1:0] mem_reg [SLOTS];
    logic [SLOT_W-1:0] rd_reg;
    logic [SLOT_W-1:0] rd_next;

    // Registered read of the addressed slot
    always_comb begin
        rd_next = mem_reg[bus.rd_slot];
    end

    // Slots survive reset; only the read register clears
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_reg[wr_slot] <= wr_word;
        end
        if (sys_rst) begin
            rd_reg <= WORD_RST;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign bus.rd_word = rd_reg;

endmodule // srs_ratio_store

// ===== rtl/srs_dsm.sv
/*
 * First-order delta-sigma modulator: dithers the integer divide value
 * so that its mean equals the fractional loop ratio.
 * Assumes one tick per internal timing clock period.
 */
`timescale 1ns/1ps
module srs_dsm
    import srs_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Core side
    srs_if.dsm        bus
);

    logic [FRAC_W-1:0] acc_reg;
    logic [FRAC_W-1:0] acc_next;
    logic [DIV_W-1:0]  div_reg;
    logic [DIV_W-1:0]  div_next;
    logic [FRAC_W:0]   sum;

    // Accumulate fraction; carry bumps the divide value by one
    always_comb begin
        sum      = {1'b0, acc_reg} + {1'b0, bus.loop_ratio[FRAC_W-1:0]};
        acc_next = acc_reg;
        div_next = div_reg;
        if (bus.restart) begin
            acc_next = ACC_RST;
            div_next = {1'b0, bus.loop_ratio[LOOP_W-1:FRAC_W]};
        end else if (bus.tick) begin
            acc_next = sum[FRAC_W-1:0];
            div_next = {1'b0, bus.loop_ratio[LOOP_W-1:FRAC_W]}
                     + {{(DIV_W-1){1'b0}}, sum[FRAC_W]};   // [R16]
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            acc_reg <= ACC_RST;
            div_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            div_reg <= div_next;
        end
    end

    assign bus.div_value = div_reg;

endmodule // srs_dsm

// ===== sim/srs_checker.sv
/* Concurrent checks on the top ports of the ratio selector.
   Assumes bind from the bench and globals static between resets. */
`timescale 1ns/1ps
module srs_checker
    import srs_pkg::*;
#(
    parameter int LOCK_CYC = 16
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               sys_rst,
    // Pins and globals
    input wire logic [1:0]         config_set_select_pins,
    input wire logic               aux_mode_pin,
    input wire logic               reference_input_pin,
    input wire logic [2:0]         aux_pin_function,
    input wire logic [1:0]         ref_divider_select,
    // Results
    input wire logic [RATIO_W-1:0] effective_ratio,
    input wire logic [LOOP_W-1:0]  loop_ratio,
    input wire logic               internal_timing_clock,
    input wire logic [1:0]         config_set_active,
    input wire logic               ratio_scaler_active,
    input wire logic               lock_lost
);
    logic [3:0]  run_reg, run_next;
    logic [31:0] hi_reg, hi_next;
    logic [1:0]  pshift;
    logic        run_ok;

    // ========================================================
    // Helpers
    // Cycles since reset, length of the settling run
    always_comb begin
        run_next = (run_reg == 4'hF) ? run_reg : run_reg + 4'h1;
        hi_next  = lock_lost ? hi_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_reg <= 4'h0;
            hi_reg  <= 32'h0;
        end else begin
            run_reg <= run_next;
            hi_reg  <= hi_next;
        end
    end
    assign run_ok = (run_reg > 4'h8);
    // Shift implied by the divider code
    always_comb begin
        case (ref_divider_select)
            2'h0:    pshift = 2'h2;
            2'h1:    pshift = 2'h1;
            default: pshift = 2'h0;
        endcase
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_reset_settle: assert property (run_reg == 4'h1 |-> lock_lost)
        else $error("lock_lost low right after reset");
    chk_loop_shift: assert property (run_ok |->
        loop_ratio == ({2'h0, $past(effective_ratio)} << pshift))
        else $error("loop ratio not the shifted effective ratio");
    chk_scaler_gate: assert property (ratio_scaler_active |-> aux_pin_function == 3'h3)
        else $error("scaler active under another aux function");
    chk_scaler_on: assert property (
        (run_ok && aux_pin_function == 3'h3 && aux_mode_pin) [*6] |-> ratio_scaler_active)
        else $error("scaler not enabled by high aux pin");
    chk_scaler_off: assert property ((run_ok && !aux_mode_pin) [*6] |-> !ratio_scaler_active)
        else $error("scaler enabled with aux pin low");
    chk_set_follow: assert property ((run_ok && $stable(config_set_select_pins)) [*6]
        |-> config_set_active == config_set_select_pins)
        else $error("active set differs from mode pins");
    chk_lock_drop: assert property ($changed(config_set_active) |-> lock_lost)
        else $error("set change without lock loss");
    chk_lock_hold: assert property ($fell(lock_lost) |-> hi_reg >= LOCK_CYC - 2)
        else $error("lock regained too early");
    chk_tick_pulse: assert property (internal_timing_clock |=> !internal_timing_clock)
        else $error("timing tick longer than one cycle");
    chk_tick_div1: assert property (run_ok && ref_divider_select == 2'h2
        && $rose(reference_input_pin) |-> ##[1:5] internal_timing_clock)
        else $error("no tick for reference edge at divide by one");
endmodule // srs_checker

// ===== sim/srs_partner.sv
/* Far side: outside logic on the mode pins and a free running reference.
   Assumes requests change on rising mclk edges. */
`timescale 1ns/1ps
module srs_partner (
    // Clock
    input  wire logic       mclk,
    // Requests from the bench
    input  wire logic [1:0] set_req,
    input  wire logic       aux_req,
    input  wire logic [7:0] ref_half,
    // Pins toward the block
    output logic [1:0]      config_set_select_pins,
    output logic            aux_mode_pin,
    output logic            reference_input_pin
);
    int half_cnt;
    // Quiet start
    initial begin
        half_cnt = 0;
        reference_input_pin = 1'b0;
        config_set_select_pins = 2'h0;
        aux_mode_pin = 1'b0;
    end
    // Reference high and low ref_half cycles each
    always @(posedge mclk) begin
        if (half_cnt + 1 >= int'(ref_half)) begin
            half_cnt <= 0;
            reference_input_pin <= ~reference_input_pin;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end
    // Mode pins hold static levels between requests
    always @(posedge mclk) begin
        config_set_select_pins <= set_req;
        aux_mode_pin <= aux_req;
    end
endmodule // srs_partner

// ===== sim/srs_top_bench.sv
/* Self-checking bench of the ratio selector with its pin partner.
   Assumes package, interface and design compiled first. */
`timescale 1ns/1ps
module srs_top_bench;
    import srs_pkg::*;
    localparam int LK = 16;
    // ========================================================
    // Signals
    logic               mclk, sys_rst, aux_mode_pin, reference_input_pin, otp_wr_en;
    logic               internal_timing_clock, ratio_scaler_active, lock_lost, aux_req;
    logic [1:0]         config_set_select_pins, ref_divider_select, otp_wr_slot;
    logic [1:0]         otp_wr_scale, config_set_active, set_req;
    logic [2:0]         aux_pin_function;
    logic [7:0]         ref_half;
    logic [19:0]        acc;
    logic [RATIO_W-1:0] otp_wr_ratio, effective_ratio;
    logic [LOOP_W-1:0]  loop_ratio;
    logic [DIV_W-1:0]   loop_divide_value;
    logic [RATIO_W-1:0] rat [4];
    int                 seed, miscompares, num_checks, n, s, a;

    srs_top #(.LOCK_CYC(LK)) dut (.mclk, .sys_rst, .config_set_select_pins, .aux_mode_pin,
        .reference_input_pin, .aux_pin_function, .ref_divider_select, .otp_wr_en,
        .otp_wr_slot, .otp_wr_ratio, .otp_wr_scale, .effective_ratio, .loop_ratio,
        .loop_divide_value, .internal_timing_clock, .config_set_active,
        .ratio_scaler_active, .lock_lost);
    srs_partner pins (.mclk, .set_req, .aux_req, .ref_half, .config_set_select_pins,
        .aux_mode_pin, .reference_input_pin);

    // Clock
    always #2.5 mclk = ~mclk;

    // ========================================================
    // Expectations: slot s is written with scale code s
    function automatic logic [RATIO_W-1:0] exp_eff(input int i, input logic on);
        return on ? rat[i] >> (i + 1) : rat[i];
    endfunction
    function automatic logic [LOOP_W-1:0] exp_loop(input logic [RATIO_W-1:0] r);
        return {2'h0, r} << ((ref_divider_select == 2'h0) ? 2 :
                             (ref_divider_select == 2'h1) ? 1 : 0);
    endfunction

    // ========================================================
    // Tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic timeout(input string what);
        miscompares++;
        $display("ERROR %0t wait ran out: %s", $time, what);
        report_and_stop();
    endtask
    task automatic do_reset(input logic [2:0] fn, input logic [1:0] code);
        @(posedge mclk);
        sys_rst <= 1'b1;
        aux_pin_function <= fn;
        ref_divider_select <= code;
        ref_half <= (code == 2'h2) ? 8'h0C : (code == 2'h1) ? 8'h06 : 8'h03;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
    endtask
    task automatic go_set(input int i, input int on);
        @(posedge mclk);
        set_req <= 2'(i);
        aux_req <= 1'(on);
        repeat (12) @(posedge mclk);
        #1;
    endtask
    task automatic wait_lock(output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 300; k++) begin
            @(posedge mclk);
            #1;
            if (lock_lost === 1'b1) cnt++;
            else if (cnt > 0) break;
        end
        if (k == 300) timeout("lock");
    endtask
    task automatic wait_tick();
        int k;
        for (k = 0; k < 60; k++) begin
            @(posedge mclk);
            #1;
            if (internal_timing_clock === 1'b1) break;
        end
        if (k == 60) timeout("tick");
    endtask

    // ========================================================
    // Main sequence
    initial begin
        mclk = 1'b0; sys_rst = 1'b1; aux_req = 1'b0; set_req = 2'h0; ref_half = 8'h0C;
        aux_pin_function = 3'h3; ref_divider_select = 2'h2; otp_wr_en = 1'b0;
        otp_wr_slot = 2'h0; otp_wr_scale = 2'h0; otp_wr_ratio = 32'h0;
        seed = 63; miscompares = 0; num_checks = 0;
        do_reset(3'h3, 2'h2);
        // Four slots back to back, low bits clear so no scale truncates
        @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            rat[i] = ($random(seed) & 32'h0FFF_FFF0) | 32'h0010_0000;
            otp_wr_en <= 1'b1;
            otp_wr_slot <= 2'(i);
            otp_wr_ratio <= rat[i];
            otp_wr_scale <= 2'(i);
            @(posedge mclk);
        end
        otp_wr_en <= 1'b0;
        // Each divider code: every set, shift, and tick rate
        for (int c = 2; c >= 0; c--) begin
            do_reset(3'h3, 2'(c));
            for (int i = 0; i < 4; i++) begin
                go_set(i, 0);
                chk(config_set_active === 2'(i), "active set");
                chk(effective_ratio === exp_eff(i, 1'b0), "plain ratio");
                chk(loop_ratio === exp_loop(rat[i]), "loop ratio");
            end
            n = 0;
            repeat (192) begin
                @(posedge mclk);
                #1;
                if (internal_timing_clock === 1'b1) n++;
            end
            chk(n == 8, "tick count");
            $display("divider code %0d done", c);
        end
        // Scaler on each set, then off again with the slot unchanged
        for (int i = 0; i < 4; i++) begin
            go_set(i, 1);
            chk(ratio_scaler_active === 1'b1, "scaler on");
            chk(effective_ratio === exp_eff(i, 1'b1), "scaled");
            chk(loop_ratio === exp_loop(exp_eff(i, 1'b1)), "scaled loop");
            go_set(i, 0);
            chk(effective_ratio === exp_eff(i, 1'b0), "restored");
        end
        repeat (8) begin
            s = $random(seed) & 3;
            a = $random(seed) & 1;
            go_set(s, a);
            chk(effective_ratio === exp_eff(s, 1'(a)), "random mode");
        end
        do_reset(3'h0, 2'h2);
        go_set(1, 1);
        chk(ratio_scaler_active === 1'b0, "scaler gated");
        chk(effective_ratio === exp_eff(1, 1'b0), "unscaled");
        $display("scaler test done");
        // Settling after a set change, then dither of 5.5
        do_reset(3'h3, 2'h2);
        @(posedge mclk);
        otp_wr_en <= 1'b1;
        otp_wr_slot <= 2'h1;
        otp_wr_ratio <= 32'h0058_0000;
        set_req <= 2'h0;
        aux_req <= 1'b0;
        @(posedge mclk);
        otp_wr_en <= 1'b0;
        wait_lock(n);
        chk(n >= LK, "reset settle");
        @(posedge mclk);
        set_req <= 2'h1;
        wait_lock(n);
        chk(n >= LK && n <= LK + 6, "settle time");
        acc = 20'h0_0000;
        for (int k = 0; k < 8; k++) begin
            wait_tick();
            repeat (2) @(posedge mclk);
            #1;
            acc = acc + 20'(loop_divide_value);
        end
        chk(acc === 20'h0_002C, "dither mean");
        $display("lock and dither test done");
        report_and_stop();
    end
endmodule // srs_top_bench

bind srs_top srs_checker #(.LOCK_CYC(LOCK_CYC)) chk_i (.mclk, .sys_rst,
    .config_set_select_pins, .aux_mode_pin, .reference_input_pin, .aux_pin_function,
    .ref_divider_select, .effective_ratio, .loop_ratio, .internal_timing_clock,
    .config_set_active, .ratio_scaler_active, .lock_lost);
